// *** octp_host_model.sv ***
// Host side of the control port: page select, offset and strobes.
// Assumes access is called from a falling edge of clk_in.
`timescale 1ns/10ps
module octp_host_model (
    // Clock and read answer
    input  wire logic       clk_in,
    input  wire logic [7:0] rd_data_in,
    input  wire logic       rd_valid_in,
    // Request
    output logic      [7:0] page_out,
    output logic      [7:0] addr_out,
    output logic      [7:0] data_out,
    output logic            wr_out,
    output logic            rd_out
);
    initial begin
        page_out = 8'h00;
        addr_out = 8'h00;
        data_out = 8'h00;
        wr_out   = 1'b0;
        rd_out   = 1'b0;
    end
    // Data is inverted on release so a stale byte cannot pass for a fresh one
    task automatic access(input logic wr, input logic [7:0] pg, ad, dt, output logic [7:0] q, output logic v);
        @(negedge clk_in);
        page_out = pg;
        addr_out = ad;
        data_out = dt;
        wr_out   = wr;
        rd_out   = !wr;
        @(negedge clk_in);
        q        = rd_data_in;
        v        = rd_valid_in;
        wr_out   = 1'b0;
        rd_out   = 1'b0;
        data_out = ~dt;
    endtask : access
endmodule : octp_host_model

// *** octp_pkg.sv ***
// Constants for the offset-calibration trim page register bank.
// Assumes an 8-bit control port that carries a page number and a register offset.
package octp_pkg;
    localparam logic [7:0] OCTP_PAGE          = 8'hFD;
    localparam logic [7:0] OCTP_OFS_SPARE_A   = 8'h09;
    localparam logic [7:0] OCTP_OFS_DITHER_A  = 8'h0A;
    localparam logic [7:0] OCTP_OFS_CAL_CFG   = 8'h0B;
    localparam logic [7:0] OCTP_OFS_DITH_MID  = 8'h0C;
    localparam logic [7:0] OCTP_OFS_DITH_HIGH = 8'h0D;
    localparam logic [7:0] OCTP_OFS_SPEEDUP   = 8'h0E;
    localparam logic [7:0] OCTP_OFS_PROT      = 8'h0F;
    localparam int         OCTP_NUM_REGS      = 7;

    localparam logic [2:0] OCTP_IDX_DITHER_A  = 3'h1;
    localparam logic [2:0] OCTP_IDX_CAL_CFG   = 3'h2;
    localparam logic [2:0] OCTP_IDX_DITH_MID  = 3'h3;
    localparam logic [2:0] OCTP_IDX_DITH_HIGH = 3'h4;
    localparam logic [2:0] OCTP_IDX_SPEEDUP   = 3'h5;
    localparam logic [2:0] OCTP_IDX_PROT      = 3'h6;

    localparam int OCTP_BIT_DITHER         = 7;
    localparam int OCTP_BIT_FILTER_BYPASS  = 4;
    localparam int OCTP_BIT_FULL_SPAN      = 3;
    localparam int OCTP_BIT_AVERAGING      = 2;
    localparam int OCTP_BIT_FINE_DISABLE   = 1;
    localparam int OCTP_BIT_POST_AVG_DIS   = 0;
    localparam int OCTP_BIT_CLK_LOSS_SPEED = 4;
    localparam int OCTP_BIT_ANALOG_SPEED   = 0;
    localparam int OCTP_BIT_SHORT_DIS_N    = 4;
    localparam int OCTP_BIT_REPEAT_DIS     = 0;

    localparam logic [7:0] OCTP_RST_DEFAULT = 8'h00;
    localparam logic [7:0] OCTP_RST_PROT    = 8'h10;
    localparam logic [7:0] OCTP_READ_NONE   = 8'h00;

    localparam logic [6:0] OCTP_COARSE_SPLIT = 7'h40;
    localparam logic [6:0] OCTP_COARSE_ONLY  = 7'h60;
    localparam logic [5:0] OCTP_FINE_SPLIT   = 6'h20;
    localparam logic [5:0] OCTP_FINE_NONE    = 6'h00;

    typedef enum logic [1:0] {
        OCTP_BOND_RESERVED,
        OCTP_BOND_MID,
        OCTP_BOND_HIGH,
        OCTP_BOND_OTHER
    } octp_bond_e;
endpackage : octp_pkg

// *** octp_trim_page.sv ***
// Offset-calibration trim and test register bank, offsets 0x09..0x0F of the test page.
// Assumes the control-port decoder and the analog engines run on clk_in.
// All outputs are registered; calibration outputs hold between run starts.
// Overview of operation
// - Offset 0x0B bit 4 set bypasses the front-end calibration filter.
// - Offset 0x0B bit 3 widens the filter window from last half to whole period.
// - Offset 0x0B bit 2 selects averaging instead of majority filtering.
// - Offset 0x0B bit 1 picks 96 coarse steps, else 64 coarse plus 32 fine.
// - Offset 0x0B bit 0 takes raw integrator output instead of post-averaged result.
// - Offset 0x0F bit 4 is inverted short-detect enable, resetting to disabled.
// - Offset 0x0F bit 0 blocks every offset cancellation after the first one.
// - Offset 0x0E bit 4 speeds up lost-clock detection; reset gives normal timing.
// - Offset 0x0E bit 0 speeds up analog power sequencing; reset gives normal timing.
// - Bit 7 of 0x0A and 0x0B apply dither only under the reserved bond option.
// - Bit 7 of 0x0C applies dither only under the mid bond option.
// - Bit 7 of 0x0D applies dither only under the high bond option.
// - Accesses hit these registers only while the test page is selected.
`timescale 1ns/10ps
module octp_trim_page
    import octp_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    // Control port
    input  wire logic [7:0] page_sel_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic       wr_en_in,
    input  wire logic [7:0] wr_data_in,
    input  wire logic       rd_en_in,
    output logic      [7:0] rd_data_out,
    output logic            rd_valid_out,
    // Bond option and engine handshakes
    input  wire logic [1:0] bond_option_in,
    input  wire logic       cal_start_in,
    input  wire logic       offset_cancel_req_in,
    output logic            offset_cancel_go_out,
    // Calibration configuration, held for the current run
    output logic            cal_filter_bypass_out,
    output logic            cal_filter_full_span_out,
    output logic            cal_filter_averaging_out,
    output logic      [6:0] cal_coarse_steps_out,
    output logic      [5:0] cal_fine_steps_out,
    output logic            cal_post_average_disable_out,
    // Dither and protection controls
    output logic      [1:0] dither_adjust_out,
    output logic            short_detect_enable_out,
    output logic            clock_loss_detect_speedup_out,
    output logic            analog_sequence_speedup_out
);

    typedef struct packed {
        // Register file, one byte per offset from 0x09
        logic [OCTP_NUM_REGS-1:0][7:0] regs;
        // Read answer
        logic [7:0]                    rd_data;
        logic                          rd_valid;
        // Cancel handshake
        logic                          cancel_go;
        logic                          first_cancel_done;
        // Run snapshot
        logic                          filter_bypass;
        logic                          full_span;
        logic                          averaging;
        logic [6:0]                    coarse_steps;
        logic [5:0]                    fine_steps;
        logic                          post_avg_dis;
        // Live controls
        logic [1:0]                    dither;
        logic                          short_en;
        logic                          clk_loss_speed;
        logic                          analog_speed;
    } octp_state_s;

    octp_state_s state_reg;
    octp_state_s state_next;
    logic        rst_sync1_reg;
    logic        rst_sync2_reg;

    // Page and offset both must match, other pages reuse these offsets
    function automatic logic octp_hit(input logic [7:0] page, input logic [7:0] addr);
        octp_hit = (page == OCTP_PAGE) &&
                   (addr >= OCTP_OFS_SPARE_A) &&
                   (addr <= OCTP_OFS_PROT);
    endfunction : octp_hit

    // Only meaningful after octp_hit, so the subtraction never wraps
    function automatic logic [2:0] octp_index(input logic [7:0] addr);
        logic [7:0] diff;
        diff = addr - OCTP_OFS_SPARE_A;
        octp_index = diff[2:0];
    endfunction : octp_index

    // Later cancellations are refused only once one has been granted since reset
    function automatic logic octp_cancel_ok(input logic done, input logic [7:0] prot);
        octp_cancel_ok = !(done && prot[OCTP_BIT_REPEAT_DIS]);
    endfunction : octp_cancel_ok

    // Split schedule runs coarse then fine, the other runs a longer coarse phase only
    function automatic logic [6:0] octp_coarse(input logic fine_off);
        octp_coarse = fine_off ? OCTP_COARSE_ONLY : OCTP_COARSE_SPLIT;
    endfunction : octp_coarse

    function automatic logic [5:0] octp_fine(input logic fine_off);
        octp_fine = fine_off ? OCTP_FINE_NONE : OCTP_FINE_SPLIT;
    endfunction : octp_fine

    // Dither bits are routed by bond option; an unknown option gets none,
    // so a stray strap value cannot inject dither meant for another grade
    function automatic logic [1:0] octp_dither(input octp_bond_e                    bond,
                                               input logic [OCTP_NUM_REGS-1:0][7:0] regs);
        case (bond)
            OCTP_BOND_RESERVED: begin
                octp_dither = {regs[OCTP_IDX_DITHER_A][OCTP_BIT_DITHER],
                               regs[OCTP_IDX_CAL_CFG][OCTP_BIT_DITHER]};
            end
            OCTP_BOND_MID: begin
                octp_dither = {1'b0, regs[OCTP_IDX_DITH_MID][OCTP_BIT_DITHER]};
            end
            OCTP_BOND_HIGH: begin
                octp_dither = {1'b0, regs[OCTP_IDX_DITH_HIGH][OCTP_BIT_DITHER]};
            end
            default: begin
                octp_dither = 2'h0;
            end
        endcase
    endfunction : octp_dither

    // Two flops keep the release of reset clear of the clock edge;
    // assertion stays asynchronous so outputs go safe without a clock
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end

    always_comb begin
        octp_bond_e bond;
        logic [7:0] cfg;
        // Bond option is a static strap on this clock, so no synchroniser
        bond       = octp_bond_e'(bond_option_in);
        cfg        = state_reg.regs[OCTP_IDX_CAL_CFG];
        state_next = state_reg;

        // Writes land at the strobe edge; a read in the same cycle sees the old byte
        if (wr_en_in && octp_hit(page_sel_in, reg_addr_in)) begin
            state_next.regs[octp_index(reg_addr_in)] = wr_data_in;
        end

        // Unmapped reads still answer, with zero, so the host never waits
        state_next.rd_valid = rd_en_in;
        state_next.rd_data  = OCTP_READ_NONE;
        if (rd_en_in && octp_hit(page_sel_in, reg_addr_in)) begin
            state_next.rd_data = state_reg.regs[octp_index(reg_addr_in)];
        end

        // Snapshot only at run start so a rewrite mid-run cannot disturb the engine
        if (cal_start_in) begin
            state_next.filter_bypass = cfg[OCTP_BIT_FILTER_BYPASS];
            state_next.full_span     = cfg[OCTP_BIT_FULL_SPAN];
            state_next.averaging     = cfg[OCTP_BIT_AVERAGING];
            state_next.post_avg_dis  = cfg[OCTP_BIT_POST_AVG_DIS];
            state_next.coarse_steps  = octp_coarse(cfg[OCTP_BIT_FINE_DISABLE]);
            state_next.fine_steps    = octp_fine(cfg[OCTP_BIT_FINE_DISABLE]);
        end

        // Static controls follow the registers one cycle behind
        state_next.dither         = octp_dither(bond, state_reg.regs);
        state_next.short_en       = ~state_reg.regs[OCTP_IDX_PROT][OCTP_BIT_SHORT_DIS_N];
        state_next.clk_loss_speed = state_reg.regs[OCTP_IDX_SPEEDUP][OCTP_BIT_CLK_LOSS_SPEED];
        state_next.analog_speed   = state_reg.regs[OCTP_IDX_SPEEDUP][OCTP_BIT_ANALOG_SPEED];

        // Grant is a one-cycle pulse; the first grant arms the repeat block
        state_next.cancel_go = 1'b0;
        if (offset_cancel_req_in &&
            octp_cancel_ok(state_reg.first_cancel_done, state_reg.regs[OCTP_IDX_PROT])) begin
            state_next.cancel_go         = 1'b1;
            state_next.first_cancel_done = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_sync2_reg) begin
        if (!rst_sync2_reg) begin
            state_reg                          <= '0;
            state_reg.regs                     <= {OCTP_NUM_REGS{OCTP_RST_DEFAULT}};
            // Short detection starts off until the host enables it
            state_reg.regs[OCTP_IDX_PROT]      <= OCTP_RST_PROT;
            state_reg.coarse_steps             <= OCTP_COARSE_SPLIT;
            state_reg.fine_steps               <= OCTP_FINE_SPLIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // Register port answers and cancel grant
    assign rd_data_out                   = state_reg.rd_data;
    assign rd_valid_out                  = state_reg.rd_valid;
    assign offset_cancel_go_out          = state_reg.cancel_go;

    // Calibration snapshot for the current run
    assign cal_filter_bypass_out         = state_reg.filter_bypass;
    assign cal_filter_full_span_out      = state_reg.full_span;
    assign cal_filter_averaging_out      = state_reg.averaging;
    assign cal_coarse_steps_out          = state_reg.coarse_steps;
    assign cal_fine_steps_out            = state_reg.fine_steps;
    assign cal_post_average_disable_out  = state_reg.post_avg_dis;

    // Live controls
    assign dither_adjust_out             = state_reg.dither;
    assign short_detect_enable_out       = state_reg.short_en;
    assign clock_loss_detect_speedup_out = state_reg.clk_loss_speed;
    assign analog_sequence_speedup_out   = state_reg.analog_speed;

endmodule : octp_trim_page

// *** octp_trim_page_props.sv ***
// Concurrent checks on the trim page ports.
// Assumes the bind below attaches it to every octp_trim_page.
`timescale 1ns/10ps
module octp_trim_page_props
    import octp_pkg::*;
(
    input wire logic       clk_in,
    input wire logic       rst_b_in,
    input wire logic [7:0] page_sel_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic       wr_en_in,
    input wire logic [7:0] wr_data_in,
    input wire logic       rd_en_in,
    input wire logic [7:0] rd_data_out,
    input wire logic       rd_valid_out,
    input wire logic [1:0] bond_option_in,
    input wire logic       cal_start_in,
    input wire logic       offset_cancel_req_in,
    input wire logic       offset_cancel_go_out,
    input wire logic       cal_filter_bypass_out,
    input wire logic [6:0] cal_coarse_steps_out,
    input wire logic [5:0] cal_fine_steps_out,
    input wire logic [1:0] dither_adjust_out,
    input wire logic       short_detect_enable_out,
    input wire logic       clock_loss_detect_speedup_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // A lone write, so the derived output two edges on reflects only it
    sequence s_wr(logic [7:0] ofs);
        wr_en_in && page_sel_in == OCTP_PAGE && reg_addr_in == ofs ##1 !wr_en_in;
    endsequence
    a_read_answer: assert property (rd_en_in |=> rd_valid_out) else $error("read not answered");
    a_unmapped_zero: assert property (rd_en_in && (page_sel_in != OCTP_PAGE || reg_addr_in < OCTP_OFS_SPARE_A
        || reg_addr_in > OCTP_OFS_PROT) |=> rd_data_out == 8'h00) else $error("unmapped read not zero");
    a_short_inverse: assert property (s_wr(OCTP_OFS_PROT)
        |=> short_detect_enable_out == !$past(wr_data_in[4], 2)) else $error("short enable wrong");
    a_loss_speedup: assert property (s_wr(OCTP_OFS_SPEEDUP)
        |=> clock_loss_detect_speedup_out == $past(wr_data_in[4], 2)) else $error("speedup wrong");
    a_step_schedule: assert property (cal_start_in |=> {cal_coarse_steps_out, cal_fine_steps_out}
        inside {13'h1020, 13'h1800}) else $error("step counts wrong");
    a_config_held: assert property (!cal_start_in |=> $stable(cal_coarse_steps_out)
        && $stable(cal_filter_bypass_out)) else $error("config changed mid run");
    a_grant_cause: assert property (offset_cancel_go_out |-> $past(offset_cancel_req_in))
        else $error("grant without request");
    a_dither_other: assert property ((bond_option_in == 2'h3) [*3] |-> dither_adjust_out == 2'h0)
        else $error("dither under other bond");
    a_dither_mid: assert property ((bond_option_in == 2'h1) [*3] |-> !dither_adjust_out[1])
        else $error("mid bond dither wrong");
endmodule : octp_trim_page_props
bind octp_trim_page octp_trim_page_props props_i (.clk_in, .rst_b_in, .page_sel_in, .reg_addr_in, .wr_en_in,
    .wr_data_in, .rd_en_in, .rd_data_out, .rd_valid_out, .bond_option_in, .cal_start_in, .offset_cancel_req_in,
    .offset_cancel_go_out, .cal_filter_bypass_out, .cal_coarse_steps_out, .cal_fine_steps_out,
    .dither_adjust_out, .short_detect_enable_out, .clock_loss_detect_speedup_out);

// *** tb.sv ***
// Self-checking bench for the trim page register bank.
// Assumes octp_host_model drives the control port.
`timescale 1ns/10ps
module tb
    import octp_pkg::*;
;
    typedef struct packed { logic [7:0] pg, ad, wd, rd; } octp_row_s;
    logic       clk_in, rst_b_in, cal_start, cancel_req, go, short_en, wr, rd, v, num_errors_flag;
    logic [7:0] page, addr, wd, rdata, q;
    logic [1:0] bond, dither;
    logic [6:0] coarse;
    logic [5:0] fine;
    wire  [3:0] cfg;
    wire  [1:0] spd;
    int         num_errors = 0;
    int         checks_done = 0;
    octp_row_s rows [11] = '{'{8'hFD, 8'h09, 8'hA5, 8'hA5}, '{8'hFD, 8'h0A, 8'h80, 8'h80},
        '{8'hFD, 8'h0B, 8'h9F, 8'h9F}, '{8'hFD, 8'h0C, 8'hFF, 8'hFF}, '{8'hFD, 8'h0D, 8'h81, 8'h81},
        '{8'hFD, 8'h0E, 8'h11, 8'h11}, '{8'hFD, 8'h0F, 8'hEF, 8'hEF}, '{8'h00, 8'h0F, 8'h00, 8'hEF},
        '{8'hFD, 8'h10, 8'h55, 8'h00}, '{8'hFD, 8'h08, 8'h55, 8'h00}, '{8'h00, 8'h09, 8'h00, 8'hA5}};
    octp_host_model host_i (.clk_in(clk_in), .rd_data_in(rdata), .rd_valid_in(v), .page_out(page),
        .addr_out(addr), .data_out(wd), .wr_out(wr), .rd_out(rd));
    octp_trim_page octp_trim_page_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .page_sel_in(page),
        .reg_addr_in(addr), .wr_en_in(wr), .wr_data_in(wd), .rd_en_in(rd), .rd_data_out(rdata),
        .rd_valid_out(v), .bond_option_in(bond), .cal_start_in(cal_start), .offset_cancel_req_in(cancel_req),
        .offset_cancel_go_out(go), .cal_filter_bypass_out(cfg[3]), .cal_filter_full_span_out(cfg[2]),
        .cal_filter_averaging_out(cfg[1]), .cal_coarse_steps_out(coarse), .cal_fine_steps_out(fine),
        .cal_post_average_disable_out(cfg[0]), .dither_adjust_out(dither), .short_detect_enable_out(short_en),
        .clock_loss_detect_speedup_out(spd[1]), .analog_sequence_speedup_out(spd[0]));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask : chk
    task automatic pulse(input logic cancel);
        @(negedge clk_in);
        cancel_req = cancel;
        cal_start  = !cancel;
        @(negedge clk_in);
        cancel_req = 1'b0;
        cal_start  = 1'b0;
    endtask : pulse
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    initial begin
        repeat (5000) @(posedge clk_in);
        num_errors++;
        report_and_stop();
    end
    initial begin
        rst_b_in = 1'b0;
        cal_start = 1'b0;
        cancel_req = 1'b0;
        bond = 2'h0;
        repeat (8) @(negedge clk_in);
        rst_b_in = 1'b1;
        repeat (3) @(negedge clk_in);
        chk("reset_steps", 8'h60, {1'b0, coarse} ^ {2'h0, fine});
        chk("short_en", 8'h00, {7'h0, short_en});
        for (int a = 9; a < 16; a++) begin
            host_i.access(1'b0, OCTP_PAGE, 8'(a), 8'h00, q, num_errors_flag);
            chk("reset_value", (a == 15) ? OCTP_RST_PROT : OCTP_RST_DEFAULT, q);
        end
        $display("reset test done");
        foreach (rows[i]) begin
            host_i.access(1'b1, rows[i].pg, rows[i].ad, rows[i].wd, q, num_errors_flag);
            host_i.access(1'b0, OCTP_PAGE, rows[i].ad, 8'h00, q, num_errors_flag);
            chk("readback", rows[i].rd, q);
            chk("rd_valid", 8'h01, {7'h0, num_errors_flag});
        end
        chk("speedups", 8'h03, {6'h0, spd});
        chk("short_en", 8'h01, {7'h0, short_en});
        $display("table test done");
        for (int b = 0; b < 4; b++) begin
            bond = 2'(b);
            repeat (4) @(negedge clk_in);
            chk("dither", (b == 0) ? 8'h03 : (b == 3) ? 8'h00 : 8'h01, {6'h0, dither});
        end
        pulse(1'b0);
        chk("cal_cfg", 8'h0F, {4'h0, cfg});
        chk("coarse", 8'h60, {1'b0, coarse});
        chk("fine", 8'h00, {2'h0, fine});
        host_i.access(1'b1, OCTP_PAGE, OCTP_OFS_CAL_CFG, 8'h00, q, num_errors_flag);
        chk("held", 8'h60, {1'b0, coarse});
        pulse(1'b0);
        chk("cal_cfg", 8'h00, {4'h0, cfg});
        chk("fine", 8'h20, {2'h0, fine});
        chk("coarse", 8'h40, {1'b0, coarse});
        $display("calibration test done");
        pulse(1'b1);
        chk("first_go", 8'h01, {7'h0, go});
        pulse(1'b1);
        chk("later_go", 8'h00, {7'h0, go});
        host_i.access(1'b1, OCTP_PAGE, OCTP_OFS_PROT, 8'hEE, q, num_errors_flag);
        pulse(1'b1);
        chk("reopened_go", 8'h01, {7'h0, go});
        $display("cancel test done");
        report_and_stop();
    end
endmodule : tb
